// *** bench/jtl_rx_model.sv ***
// Receiver model: captures the octets of each lane of both links
`timescale 1ns/10ps
`default_nettype none
module jtl_rx_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [31:0] laneData,
	input wire logic [3:0] laneValid,
	output logic [31:0] lastOctets,
	output logic [15:0] octetCount
);
	// Last octet per lane; a lane without valid keeps its old capture, so stale data shows
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lastOctets <= '0;
			octetCount <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (laneValid[i]) begin
					lastOctets[i*8 +: 8] <= laneData[i*8 +: 8];
				end
			end
			if (|laneValid) begin
				octetCount <= octetCount + 16'h0001;
			end
		end
	end
endmodule : jtl_rx_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench: register access, code table, refusals and lane mapping
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin errCount++; \
	$display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWdata = 8'h00;
	logic [1:0] linkPowerUp = 2'h0;
	logic [5:0] kValue = 6'h20;
	logic [1:0] convNBits = 2'h2;
	logic controlBits = 1'b0;
	logic [7:0] regRdata, ab0, ab1, cd0, cd1, rd;
	logic [3:0] laneValid, laneRateBand, samplesPerFrame;
	logic configValid;
	logic [1:0] laneCount, convCount;
	logic [2:0] octetsPerFrame;
	logic [5:0] latencyClocks;
	logic [7:0] rateMultiplier;
	logic [31:0] lastOctets;
	logic [15:0] octetCount;
	int errCount = 0;
	int checksDone = 0;
	int cycles = 0;
	// Resting samples; test_timing steps them once to see the one-cycle lane delay
	localparam logic [7:0] SA = 8'h1a, SB = 8'h2b, SC = 8'h3c, SD = 8'h4d;
	// Output rate the host plans lane rates around
	localparam int OUTPUT_SAMPLE_RATE_MSPS = 500;
	logic [7:0] adcA = SA, adcB = SB, adcC = SC, adcD = SD;
	always #5 ref_clk = ~ref_clk;
	jtl_link_config jtl_link_config_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .linkPowerUp(linkPowerUp), .kValue(kValue),
		.convNBits(convNBits), .controlBits(controlBits), .adcA(adcA), .adcB(adcB),
		.adcC(adcC), .adcD(adcD), .link_ab_lane0_out(ab0), .link_ab_lane1_out(ab1),
		.link_cd_lane0_out(cd0), .link_cd_lane1_out(cd1), .laneValid(laneValid),
		.configValid(configValid), .laneCount(laneCount), .convCount(convCount),
		.octetsPerFrame(octetsPerFrame), .samplesPerFrame(samplesPerFrame),
		.laneRateBand(laneRateBand), .latencyClocks(latencyClocks),
		.rateMultiplier(rateMultiplier));
	jtl_rx_model jtl_rx_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.laneData({cd1, cd0, ab1, ab0}), .laneValid(laneValid), .lastOctets(lastOctets),
		.octetCount(octetCount));
	task automatic test_done;
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	// Ceiling well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errCount++;
			test_done();
		end
	end
	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : reg_wr
	task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : reg_rd
	// Host keeps the down, configure, up order, save one refused write in test_refuse
	task automatic set_links(input logic [1:0] up);
		@(posedge ref_clk);
		linkPowerUp <= up;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : set_links
	task automatic test_reset;
		reg_rd(jtl_pkg::LANE_RATE_CONTROL_ADDR, rd);
		`CHK("rate reset", jtl_pkg::LANE_RATE_RESET, rd)
		reg_rd(jtl_pkg::LINK_QUICK_CONFIG_ADDR, rd);
		`CHK("qc reset", jtl_pkg::QUICK_CONFIG_RESET, rd)
		reg_rd(12'h571, rd);
		`CHK("unmapped", 8'h00, rd)
		$display("test_reset done");
	endtask : test_reset
	task automatic test_codes;
		logic [7:0] cd[8] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h42, 8'h09, 8'h48, 8'h49};
		int eL[8] = '{1, 1, 2, 2, 2, 1, 2, 2};
		int eM[8] = '{1, 1, 1, 1, 1, 2, 2, 2};
		int eF[8] = '{1, 2, 1, 2, 4, 2, 1, 2};
		int eS[8] = '{1, 2, 2, 4, 8, 1, 1, 2};
		int eK[8] = '{20, 12, 20, 12, 8, 12, 20, 12};
		int eR[8] = '{10, 10, 5, 5, 5, 20, 10, 10};
		int lat;
		int mbps;
		logic [7:0] rv;
		for (int i = 0; i < 8; i++) begin
			lat = jtl_pkg::LAT_ADC_SERDES + ((eM[i] > eL[i]) ? jtl_pkg::LAT_JESD_ML_TWO :
				(eM[i] < eL[i]) ? jtl_pkg::LAT_JESD_ML_HALF : jtl_pkg::LAT_JESD_ML_ONE);
			// Host picks the band from a lane rate kept inside the legal span
			mbps = eR[i] * OUTPUT_SAMPLE_RATE_MSPS;
			rv = (mbps <= 3375) ? {jtl_pkg::BAND_1G6875_3G375, 4'h0} :
				(mbps < 6750) ? jtl_pkg::LOW_LINE_RATE_VALUE : {jtl_pkg::BAND_6G75_13G5, 4'h0};
			reg_wr(jtl_pkg::LANE_RATE_CONTROL_ADDR, rv);
			kValue <= 6'(eK[i]);
			reg_wr(jtl_pkg::LINK_QUICK_CONFIG_ADDR, cd[i]);
			`CHK("valid", 1'b1, configValid)
			`CHK("L", 2'(eL[i]), laneCount)
			`CHK("M", 2'(eM[i]), convCount)
			`CHK("F", 3'(eF[i]), octetsPerFrame)
			`CHK("S", 4'(eS[i]), samplesPerFrame)
			`CHK("rate", 8'(eR[i]), rateMultiplier)
			`CHK("latency", 6'(lat), latencyClocks)
			`CHK("code band", rv[7:4], laneRateBand)
			set_links(2'h3);
			`CHK("lanes", (eL[i] == 2) ? 4'hf : 4'h5, laneValid)
			if (eL[i] == 2) begin
				`CHK("map", {(eM[i] == 2) ? SD : SC, SC, (eM[i] == 2) ? SB : SA, SA}, lastOctets)
			end else if (eM[i] == 1) begin
				`CHK("map1", {SC, SA}, {lastOctets[23:16], lastOctets[7:0]})
			end else begin
				// One lane, two converters: first ADC octet, then the held second
				`CHK("map2 first", {SC, SA}, {cd0, ab0})
				@(posedge ref_clk);
				#1;
				`CHK("map2 second", {SD, SB}, {cd0, ab0})
			end
			set_links(2'h0);
		end
		$display("test_codes done");
	endtask : test_codes
	task automatic test_refuse;
		logic [15:0] cnt;
		reg_wr(jtl_pkg::LINK_QUICK_CONFIG_ADDR, 8'h49);
		set_links(2'h1);
		reg_wr(jtl_pkg::LINK_QUICK_CONFIG_ADDR, 8'h00);
		`CHK("kept L", 2'h2, laneCount)
		`CHK("kept M", 2'h2, convCount)
		set_links(2'h0);
		reg_wr(jtl_pkg::LINK_QUICK_CONFIG_ADDR, 8'h02);
		`CHK("bad code", 1'b0, configValid)
		cnt = octetCount;
		set_links(2'h3);
		`CHK("bad lanes", 4'h0, laneValid)
		`CHK("bad octets", cnt, octetCount)
		set_links(2'h0);
		$display("test_refuse done");
	endtask : test_refuse
	task automatic test_params;
		logic [5:0] k[8] = '{6'd16, 6'd22, 6'd36, 6'd20, 6'd20, 6'd20, 6'd32, 6'd20};
		logic [1:0] n[8] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
		logic cs[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		reg_wr(jtl_pkg::LINK_QUICK_CONFIG_ADDR, 8'h48);
		for (int i = 0; i < 8; i++) begin
			kValue <= k[i];
			convNBits <= n[i];
			controlBits <= cs[i];
			set_links(2'h3);
			`CHK("param lanes", (i >= 6) ? 4'hf : 4'h0, laneValid)
			set_links(2'h0);
		end
		$display("test_params done");
	endtask : test_params
	// Lane octets follow the samples one cycle later, per converter
	task automatic test_timing;
		set_links(2'h3);
		@(posedge ref_clk);
		adcA <= 8'h5e;
		adcB <= 8'h6f;
		adcC <= 8'h70;
		adcD <= 8'h81;
		#1;
		`CHK("old sample", {SD, SC, SB, SA}, {cd1, cd0, ab1, ab0})
		@(posedge ref_clk);
		#1;
		`CHK("new sample", {8'h81, 8'h70, 8'h6f, 8'h5e}, {cd1, cd0, ab1, ab0})
		adcA <= SA;
		adcB <= SB;
		adcC <= SC;
		adcD <= SD;
		set_links(2'h0);
		$display("test_timing done");
	endtask : test_timing
	task automatic test_band;
		logic [7:0] v[4] = '{jtl_pkg::LOW_LINE_RATE_VALUE, 8'h30, 8'h00, 8'h50};
		for (int i = 0; i < 4; i++) begin
			reg_wr(jtl_pkg::LANE_RATE_CONTROL_ADDR, v[i]);
			reg_rd(jtl_pkg::LANE_RATE_CONTROL_ADDR, rd);
			`CHK("rate reg", v[i], rd)
			`CHK("band", v[i][7:4], laneRateBand)
		end
		$display("test_band done");
	endtask : test_band
	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		test_reset();
		test_codes();
		test_refuse();
		test_params();
		test_timing();
		test_band();
		test_done();
	end
endmodule : tb_top
`default_nettype wire

// *** rtl/jtl_link_config.sv ***
// Top: two transmit links, quick-configuration and lane-rate registers
//
// Functional notes
// - Two independent links, AB and CD, two lanes (the code shares one configuration between them)
// - One quick-configuration code sets L, M, F
// - Lane rate is M*N'*10/8*fs over L
// - Converter 0 first ADC, converter 1 second
// - One-converter codes 00,01,40,41,42 as tabled
// - Two-converter codes 09,48,49 as tabled
// - HD 0, N 7-8, N' 8, CS 0-1 (the code accepts CS 0 only)
// - K multiple of 4, F-dependent minimum, max 32
// - Latency fixed per mode and configuration
// - ADC plus serializer latency is 31 clocks
// - Block latency 23, 14, 7 by M/L
`timescale 1ns/10ps
`default_nettype none
module jtl_link_config #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	output logic [DATA_W-1:0] regRdata,
	input wire logic [jtl_pkg::NUM_LINKS-1:0] linkPowerUp,
	input wire logic [5:0] kValue,
	input wire logic [1:0] convNBits,
	input wire logic controlBits,
	input wire logic [jtl_pkg::SAMPLE_BITS-1:0] adcA,
	input wire logic [jtl_pkg::SAMPLE_BITS-1:0] adcB,
	input wire logic [jtl_pkg::SAMPLE_BITS-1:0] adcC,
	input wire logic [jtl_pkg::SAMPLE_BITS-1:0] adcD,
	output logic [jtl_pkg::SAMPLE_BITS-1:0] link_ab_lane0_out,
	output logic [jtl_pkg::SAMPLE_BITS-1:0] link_ab_lane1_out,
	output logic [jtl_pkg::SAMPLE_BITS-1:0] link_cd_lane0_out,
	output logic [jtl_pkg::SAMPLE_BITS-1:0] link_cd_lane1_out,
	output logic [3:0] laneValid,
	output logic configValid,
	output logic [1:0] laneCount,
	output logic [1:0] convCount,
	output logic [2:0] octetsPerFrame,
	output logic [3:0] samplesPerFrame,
	output logic [3:0] laneRateBand,
	output logic [5:0] latencyClocks,
	output logic [7:0] rateMultiplier
);
	typedef enum logic [2:0] {
		ST_DOWN = 3'b001,
		ST_CONFIG = 3'b010,
		ST_UP = 3'b100
	} jtl_state_type;

	typedef struct packed {
		logic [DATA_W-1:0] laneRate;
		logic [DATA_W-1:0] quickCfg;
		jtl_state_type state;
		jtl_pkg::jtl_cfg_type cfg;
		logic [DATA_W-1:0] rdata;
	} jtl_top_type;
	jtl_top_type st_r, st_nxt;

	logic allDown;
	logic paramsOk;
	jtl_pkg::jtl_cfg_type decoded;

	jtl_link_if linkAb ();
	jtl_link_if linkCd ();

	assign allDown = (linkPowerUp == '0);
	assign decoded = jtl_pkg::decode_cfg(st_r.quickCfg);
	// N must be 7 or 8 and CS must be 0; HD is fixed off here
	assign paramsOk = jtl_pkg::k_legal(kValue, st_r.cfg.kMin)
		&& (convNBits != 2'd0) && (convNBits != 2'd3) && !controlBits;

	// Register access, and the power/configure sequence both links share
	always_comb begin
		st_nxt = st_r;
		if (regWrite) begin
			if (regAddr == ADDR_W'(jtl_pkg::LANE_RATE_CONTROL_ADDR)) begin
				st_nxt.laneRate = regWdata;
			end
			// Config is only taken while links are down; the host keeps the order
			if (regAddr == ADDR_W'(jtl_pkg::LINK_QUICK_CONFIG_ADDR) && allDown) begin
				st_nxt.quickCfg = regWdata;
			end
		end
		st_nxt.rdata = '0;
		if (regRead) begin
			if (regAddr == ADDR_W'(jtl_pkg::LANE_RATE_CONTROL_ADDR)) begin
				st_nxt.rdata = st_r.laneRate;
			end else if (regAddr == ADDR_W'(jtl_pkg::LINK_QUICK_CONFIG_ADDR)) begin
				st_nxt.rdata = st_r.quickCfg;
			end
		end
		case (st_r.state)
			ST_DOWN: begin
				st_nxt.state = ST_CONFIG;
			end
			ST_CONFIG: begin
				st_nxt.cfg = decoded;
				if (!allDown) begin
					st_nxt.state = ST_UP;
				end
			end
			ST_UP: begin
				if (allDown) begin
					st_nxt.state = ST_CONFIG;
				end
			end
			default: begin
				st_nxt.state = ST_DOWN;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r.laneRate <= jtl_pkg::LANE_RATE_RESET;
			st_r.quickCfg <= jtl_pkg::QUICK_CONFIG_RESET;
			st_r.state <= ST_DOWN;
			st_r.cfg <= '0;
			st_r.rdata <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Each link gets the shared settings; the CD pair uses its own power enable
	assign linkAb.cfg = paramsOk ? st_r.cfg : '0;
	assign linkCd.cfg = paramsOk ? st_r.cfg : '0;
	assign linkAb.linkUp = linkPowerUp[0] && st_r.state == ST_UP;
	assign linkCd.linkUp = linkPowerUp[1] && st_r.state == ST_UP;
	assign linkAb.sampleFirst = adcA;
	assign linkAb.sampleSecond = adcB;
	assign linkCd.sampleFirst = adcC;
	assign linkCd.sampleSecond = adcD;

	jtl_link_framer framerAb (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.link(linkAb.framer)
	);
	jtl_link_framer framerCd (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.link(linkCd.framer)
	);

	assign link_ab_lane0_out = linkAb.lane0Octet;
	assign link_ab_lane1_out = linkAb.lane1Octet;
	assign link_cd_lane0_out = linkCd.lane0Octet;
	assign link_cd_lane1_out = linkCd.lane1Octet;
	assign laneValid = {linkCd.lane1Valid, linkCd.lane0Valid, linkAb.lane1Valid, linkAb.lane0Valid};
	assign regRdata = st_r.rdata;

	// Status for software and receiver setup
	assign configValid = st_r.cfg.valid && paramsOk;
	assign laneCount = st_r.cfg.lanes;
	assign convCount = st_r.cfg.convs;
	assign octetsPerFrame = st_r.cfg.octets;
	assign samplesPerFrame = st_r.cfg.samples;
	assign laneRateBand = st_r.laneRate[jtl_pkg::BAND_MSB:jtl_pkg::BAND_LSB];
	// Fixed by configuration alone, so repeatable across link resets
	assign latencyClocks = st_r.cfg.latency;
	// Lane rate over output rate, in whole units: M*N'*10/8/L
	assign rateMultiplier = (st_r.cfg.lanes == 2'd0) ? 8'h00 :
		8'((10 * jtl_pkg::NPRIME / 8) * 32'(st_r.cfg.convs) / 32'(st_r.cfg.lanes));

	chk_cfg_held_up: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && $past(st_r.state) == ST_UP |-> $stable(st_r.cfg))
		else $error("configuration changed while link up");
	chk_qc_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
		regWrite && !allDown |=> $stable(st_r.quickCfg))
		else $error("quick configuration taken while powered");
	chk_latency_sum: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.cfg.valid |-> latencyClocks >= 6'(jtl_pkg::LAT_ADC_SERDES + jtl_pkg::LAT_JESD_ML_TWO))
		else $error("latency below fixed part");
	chk_ml_half: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.cfg.valid && st_r.cfg.convs == 2'd1 && st_r.cfg.lanes == 2'd2
		|-> latencyClocks == 6'(jtl_pkg::LAT_ADC_SERDES + jtl_pkg::LAT_JESD_ML_HALF))
		else $error("wrong latency for M/L of one half");
	chk_rate_0x09: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && st_r.quickCfg == jtl_pkg::QC_M2L1F2S1 |-> rateMultiplier == 8'd20)
		else $error("code 09 lane rate not twenty");
	chk_rate_0x40: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && st_r.quickCfg == jtl_pkg::QC_L2F1S2 |-> rateMultiplier == 8'd5)
		else $error("code 40 lane rate not five");
	chk_k_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
		kValue > 6'(jtl_pkg::K_MAX) |-> !configValid)
		else $error("K above limit accepted");
	chk_bad_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && !decoded.valid |=> laneValid == 4'h0)
		else $error("lanes active on unsupported code");

	// CD power must never light AB lanes, and the reverse
	chk_cd_lanes_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!linkPowerUp[1] |=> laneValid[3:2] == 2'b00)
		else $error("CD lanes active while CD link down");
	// AB power is judged on its own enable only
	chk_ab_lanes_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!linkPowerUp[0] |=> laneValid[1:0] == 2'b00)
		else $error("AB lanes active while AB link down");
	// Single lane, single converter runs at ten times the output rate
	chk_rate_0x00: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && st_r.quickCfg == jtl_pkg::QC_L1F1S1 |-> rateMultiplier == 8'd10)
		else $error("code 00 lane rate not ten");
	// Two converters on two lanes also land on ten times
	chk_rate_0x48: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.state == ST_UP && st_r.quickCfg == jtl_pkg::QC_M2L2F1S1 |-> rateMultiplier == 8'd10)
		else $error("code 48 lane rate not ten");
	// N codes other than 7 or 8, or a CS of one, must block the link
	chk_n_cs_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
		convNBits == 2'd0 || convNBits == 2'd3 || controlBits |-> !configValid)
		else $error("illegal N or CS accepted");
	// K off the four-step grid is never accepted
	chk_k_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
		kValue[1:0] != 2'b00 |-> !configValid)
		else $error("K not a multiple of four accepted");
endmodule : jtl_link_config
`default_nettype wire

// *** rtl/jtl_link_framer.sv ***
// Framer: maps the two converters of one link onto its lane octets
`timescale 1ns/10ps
`default_nettype none
module jtl_link_framer (
	input wire logic ref_clk,
	input wire logic sys_rst,
	jtl_link_if.framer link
);
	typedef struct packed {
		logic [2:0] octetIdx;
		logic [jtl_pkg::SAMPLE_BITS-1:0] held;
		logic [jtl_pkg::SAMPLE_BITS-1:0] lane0;
		logic [jtl_pkg::SAMPLE_BITS-1:0] lane1;
		logic v0;
		logic v1;
	} jtl_frm_type;
	jtl_frm_type st_r, st_nxt;

	// Converter 0 carries the first ADC, converter 1 the second
	always_comb begin
		st_nxt = st_r;
		st_nxt.v0 = 1'b0;
		st_nxt.v1 = 1'b0;
		if (link.linkUp && link.cfg.valid) begin
			if (link.cfg.convs == 2'd2 && link.cfg.lanes == 2'd2) begin
				st_nxt.lane0 = link.sampleFirst;
				st_nxt.lane1 = link.sampleSecond;
				st_nxt.v0 = 1'b1;
				st_nxt.v1 = 1'b1;
			end else if (link.cfg.convs == 2'd2) begin
				// One lane, two converters: octets alternate, second held one cycle
				st_nxt.lane0 = (st_r.octetIdx[0]) ? st_r.held : link.sampleFirst;
				st_nxt.held = link.sampleSecond;
				st_nxt.octetIdx = st_r.octetIdx + 3'd1;
				st_nxt.v0 = 1'b1;
			end else begin
				// One converter: first ADC only, copied to both lanes when L is 2
				st_nxt.lane0 = link.sampleFirst;
				st_nxt.lane1 = link.sampleFirst;
				st_nxt.v0 = 1'b1;
				st_nxt.v1 = (link.cfg.lanes == 2'd2);
			end
		end else begin
			st_nxt.octetIdx = 3'd0;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.lane0Octet = st_r.lane0;
	assign link.lane1Octet = st_r.lane1;
	assign link.lane0Valid = st_r.v0;
	assign link.lane1Valid = st_r.v1;

	chk_invalid_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!link.cfg.valid |=> !st_r.v0 && !st_r.v1)
		else $error("lane output while configuration invalid");
	chk_first_adc_lane0: assert property (@(posedge ref_clk) disable iff (sys_rst)
		link.linkUp && link.cfg.valid && link.cfg.lanes == 2'd2
		|=> st_r.lane0 == $past(link.sampleFirst))
		else $error("lane 0 not carrying first converter");
endmodule : jtl_link_framer
`default_nettype wire

// *** rtl/jtl_link_if.sv ***
// Interface: per-link settings and sample stream between top and framer
`timescale 1ns/10ps
`default_nettype none
interface jtl_link_if;
	jtl_pkg::jtl_cfg_type cfg;
	logic linkUp;
	logic [jtl_pkg::SAMPLE_BITS-1:0] sampleFirst;
	logic [jtl_pkg::SAMPLE_BITS-1:0] sampleSecond;
	logic [jtl_pkg::SAMPLE_BITS-1:0] lane0Octet;
	logic [jtl_pkg::SAMPLE_BITS-1:0] lane1Octet;
	logic lane0Valid;
	logic lane1Valid;
	modport framer (input cfg, linkUp, sampleFirst, sampleSecond,
		output lane0Octet, lane1Octet, lane0Valid, lane1Valid);
	modport ctrl (output cfg, linkUp, sampleFirst, sampleSecond,
		input lane0Octet, lane1Octet, lane0Valid, lane1Valid);
endinterface : jtl_link_if
`default_nettype wire

// *** rtl/jtl_pkg.sv ***
// Package: register map, quick-configuration codes, latency figures
package jtl_pkg;
	localparam logic [11:0] LANE_RATE_CONTROL_ADDR = 12'h56e;
	localparam logic [11:0] LINK_QUICK_CONFIG_ADDR = 12'h570;
	localparam logic [7:0] LANE_RATE_RESET = 8'h00;
	localparam logic [7:0] QUICK_CONFIG_RESET = 8'h48;
	localparam int BAND_MSB = 7;
	localparam int BAND_LSB = 4;
	localparam logic [3:0] BAND_ABOVE_13G5 = 4'h3;
	localparam logic [3:0] BAND_6G75_13G5 = 4'h0;
	localparam logic [3:0] BAND_MID_LOW = 4'h1;
	localparam logic [3:0] BAND_1G6875_3G375 = 4'h5;
	localparam logic [7:0] LOW_LINE_RATE_VALUE = 8'h10;
	// Supported quick-configuration codes
	localparam logic [7:0] QC_L1F1S1 = 8'h00;
	localparam logic [7:0] QC_L1F2S2 = 8'h01;
	localparam logic [7:0] QC_L2F1S2 = 8'h40;
	localparam logic [7:0] QC_L2F2S4 = 8'h41;
	localparam logic [7:0] QC_L2F4S8 = 8'h42;
	localparam logic [7:0] QC_M2L1F2S1 = 8'h09;
	localparam logic [7:0] QC_M2L2F1S1 = 8'h48;
	localparam logic [7:0] QC_M2L2F2S2 = 8'h49;
	localparam int SAMPLE_BITS = 8;
	localparam int NPRIME = 8;
	localparam int NUM_LINKS = 2;
	localparam int LANES_PER_LINK = 2;
	localparam int MAX_F = 4;
	localparam int K_MAX = 32;
	localparam int K_STEP = 4;
	localparam int LAT_ADC_SERDES = 31;
	localparam int LAT_JESD_ML_HALF = 23;
	localparam int LAT_JESD_ML_ONE = 14;
	localparam int LAT_JESD_ML_TWO = 7;
	localparam int LAT_MAX = LAT_ADC_SERDES + LAT_JESD_ML_HALF;
	typedef struct packed {
		logic valid;
		logic [1:0] lanes;
		logic [1:0] convs;
		logic [2:0] octets;
		logic [3:0] samples;
		logic [5:0] kMin;
		logic [5:0] latency;
	} jtl_cfg_type;
	// Decode one code to transport settings; unknown codes come back invalid
	function automatic jtl_cfg_type decode_cfg(input logic [7:0] code);
		jtl_cfg_type c;
		c = '0;
		c.valid = 1'b1;
		case (code)
			QC_L1F1S1: c = '{1'b1, 2'd1, 2'd1, 3'd1, 4'd1, 6'd20, 6'(LAT_ADC_SERDES + LAT_JESD_ML_ONE)};
			QC_L1F2S2: c = '{1'b1, 2'd1, 2'd1, 3'd2, 4'd2, 6'd12, 6'(LAT_ADC_SERDES + LAT_JESD_ML_ONE)};
			QC_L2F1S2: c = '{1'b1, 2'd2, 2'd1, 3'd1, 4'd2, 6'd20, 6'(LAT_ADC_SERDES + LAT_JESD_ML_HALF)};
			QC_L2F2S4: c = '{1'b1, 2'd2, 2'd1, 3'd2, 4'd4, 6'd12, 6'(LAT_ADC_SERDES + LAT_JESD_ML_HALF)};
			QC_L2F4S8: c = '{1'b1, 2'd2, 2'd1, 3'd4, 4'd8, 6'd8, 6'(LAT_ADC_SERDES + LAT_JESD_ML_HALF)};
			QC_M2L1F2S1: c = '{1'b1, 2'd1, 2'd2, 3'd2, 4'd1, 6'd12, 6'(LAT_ADC_SERDES + LAT_JESD_ML_TWO)};
			QC_M2L2F1S1: c = '{1'b1, 2'd2, 2'd2, 3'd1, 4'd1, 6'd20, 6'(LAT_ADC_SERDES + LAT_JESD_ML_ONE)};
			QC_M2L2F2S2: c = '{1'b1, 2'd2, 2'd2, 3'd2, 4'd2, 6'd12, 6'(LAT_ADC_SERDES + LAT_JESD_ML_ONE)};
			default: c = '0;
		endcase
		return c;
	endfunction : decode_cfg
	// K is legal when a multiple of four, at or above the F minimum, at most 32
	function automatic logic k_legal(input logic [5:0] k, input logic [5:0] kMin);
		return (k % 6'(K_STEP) == 6'd0) && (k >= kMin) && (k <= 6'(K_MAX));
	endfunction : k_legal
endpackage : jtl_pkg
